// File: sim/oovm_host_model.sv
// Host model: issues one command at a time on the monitor's command port
`default_nettype none
module oovm_host_model (
  // Clock
  input wire logic clk,
  // Command port
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [oovm_pkg::VOUT_W-1:0] cmd_wdata,
  input wire logic [oovm_pkg::VOUT_W-1:0] cmd_rdata,
  input wire logic cmd_ack,
  input wire logic cmd_reject
);
  timeunit 1ns;
  timeprecision 1ps;
  import oovm_pkg::*;
  // Idle port at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
  // One request, held over the taking edge; answer sampled in its cycle
  // Callers need not keep the warning threshold below the fault threshold; t_limits briefly sets the fault threshold below it
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd,
                      output logic [15:0] rd, output logic ack, output logic rej);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_code = code;
    cmd_wdata = wd;
    @(negedge clk);
    // Ack or reject stands only in the cycle after the taking edge; read data holds until the next read
    rd = cmd_rdata;
    ack = cmd_ack;
    rej = cmd_reject;
    cmd_valid = 1'b0;
    cmd_code = ~cmd_code; // Unqualified lines keep moving
    cmd_wdata = ~cmd_wdata;
  endtask
endmodule
`default_nettype wire

// File: sim/tb_top.sv
// Testbench: scenarios for the output overvoltage fault monitor
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin mismatches++; \
  $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import oovm_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, enable_on = 1'b1, bias_ok = 1'b1, other_fault_off = 1'b0;
  logic cmd_valid, cmd_write, cmd_ack, cmd_reject, ack, rej;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, cmd_rdata, rd, vout_meas = 16'h0000, setpoint_strap_pin = 16'h2000;
  logic power_stage_en, restart_pulse, vout_summary_flag, warn_f, fault_f, alert_out_n;
  int mismatches = 0, cmp_count = 0, cycles = 0, restarts = 0, n;
  logic [31:0] tbl [9] = '{32'h0040_c000, 32'h1040_c001, 32'h0042_b000, 32'h1042_b001, 32'h1041_0000,
                           32'h1041_0040, 32'h1041_00c0, 32'h0040_3000, 32'h0042_2000};
  // Clock, cycle count and hang guard
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    restarts += (restart_pulse === 1'b1);
    if (cycles == 3000) begin
      mismatches++;
      print_verdict();
    end
  end
  oovm_monitor #(.RETRY_UNIT_CYCLES(8)) i_oovm_monitor (.clk(clk), .reset_n(reset_n),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack), .cmd_reject(cmd_reject), .vout_meas(vout_meas),
    .setpoint_strap_pin(setpoint_strap_pin), .enable_on(enable_on), .bias_ok(bias_ok),
    .other_fault_off(other_fault_off), .power_stage_en(power_stage_en), .restart_pulse(restart_pulse),
    .vout_summary_flag(vout_summary_flag), .overvoltage_warning_flag(warn_f),
    .overvoltage_fault_flag(fault_f), .alert_out_n(alert_out_n));
  oovm_host_model i_oovm_host_model (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack),
    .cmd_reject(cmd_reject));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic cmd(input logic wr, input logic [7:0] code, input logic [15:0] wd);
    i_oovm_host_model.xfer(wr, code, wd, rd, ack, rej);
  endtask
  task automatic wait_cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic do_reset();
    reset_n = 1'b0;
    wait_cyc(4);
    reset_n = 1'b1;
    wait_cyc(1);
  endtask
  task automatic print_verdict();
    if (mismatches == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_defaults();
    cmd(1'b0, CMD_OV_FAULT_THR, 16'h0000);
    `CHK(rd, 16'h2333)
    cmd(1'b0, CMD_OV_WARN_THR, 16'h0000);
    `CHK(rd, 16'h228f)
    cmd(1'b0, CMD_OV_REACTION, 16'h0000);
    `CHK(rd, 16'h0080)
  endtask
  task automatic t_limits();
    foreach (tbl[i]) begin
      cmd(1'b1, tbl[i][23:16], tbl[i][15:0]);
      `CHK({ack, rej}, tbl[i][28] ? 2'b01 : 2'b10)
    end
    cmd(1'b0, CMD_CLEAR_FAULTS, 16'h0000);
    `CHK({ack, rej}, 2'b01)
    cmd(1'b0, CMD_OV_FAULT_THR, 16'h0000);
    `CHK(rd, 16'h3000)
  endtask
  task automatic t_warn();
    vout_meas = 16'h2000;
    wait_cyc(2);
    `CHK(warn_f, 1'b0)
    vout_meas = 16'h2001;
    wait_cyc(2);
    `CHK({warn_f, vout_summary_flag, alert_out_n, fault_f}, 4'b1100)
    cmd(1'b1, CMD_CLEAR_FAULTS, 16'h0000);
    `CHK(warn_f, 1'b1)
    vout_meas = 16'h0000;
    cmd(1'b1, CMD_CLEAR_FAULTS, 16'h0000);
    `CHK({warn_f, alert_out_n}, 2'b01)
  endtask
  task automatic t_latch();
    n = restarts;
    vout_meas = 16'h3001;
    wait_cyc(2);
    `CHK({fault_f, vout_summary_flag, alert_out_n, power_stage_en}, 4'b1100)
    vout_meas = 16'h0000;
    wait_cyc(100);
    `CHK({power_stage_en, fault_f, restarts == n}, 3'b011)
    setpoint_strap_pin = 16'hb000;
    do_reset();
    `CHK({power_stage_en, fault_f}, 2'b10)
    cmd(1'b0, CMD_OV_FAULT_THR, 16'h0000);
    `CHK(rd, 16'hc199)
    cmd(1'b0, CMD_OV_WARN_THR, 16'h0000);
    `CHK(rd, 16'hbe14)
    cmd(1'b1, CMD_OV_WARN_THR, 16'h2000);
    cmd(1'b1, CMD_OV_FAULT_THR, 16'h3000);
  endtask
  task automatic t_retry();
    cmd(1'b1, CMD_OV_REACTION, 16'h0089);
    n = restarts;
    vout_meas = 16'h3001;
    wait_cyc(2);
    vout_meas = 16'h2800;
    wait_cyc(40);
    `CHK({power_stage_en, restarts == n}, 2'b01)
    vout_meas = 16'h0000;
    wait_cyc(5);
    `CHK({power_stage_en, restarts == n + 1}, 2'b11)
    vout_meas = 16'h3001;
    @(negedge clk);
    vout_meas = 16'h0000;
    n = 1;
    while (restart_pulse !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    `CHK(n, 2 * 8 + 2)
  endtask
  task automatic t_stop();
    vout_meas = 16'h3001;
    wait_cyc(2);
    vout_meas = 16'h0000;
    enable_on = 1'b0;
    n = restarts;
    wait_cyc(40);
    `CHK({power_stage_en, restarts == n}, 2'b01)
    enable_on = 1'b1;
    wait_cyc(30);
    `CHK(power_stage_en, 1'b1)
    for (int k = 0; k < 2; k++) begin
      if (k == 0) bias_ok = 1'b0;
      else other_fault_off = 1'b1;
      wait_cyc(2);
      `CHK(power_stage_en, 1'b0)
      bias_ok = 1'b1;
      other_fault_off = 1'b0;
      wait_cyc(3);
      `CHK(power_stage_en, 1'b1)
    end
  endtask
  // Main sequence
  initial begin
    do_reset();
    t_defaults();
    t_limits();
    t_warn();
    t_latch();
    t_retry();
    t_stop();
    print_verdict();
  end
endmodule
`default_nettype wire

// File: verilog/oovm_monitor.sv
// Output overvoltage supervisor: thresholds, flags, alert and fault reaction
`default_nettype none
// Operation
// [R1] Thresholds are unsigned volts times 2^-13
// [R2] Out-of-range threshold writes are rejected
// [R3] Fault threshold defaults to 1.10 setpoint
// [R4] Fault sets summary and fault flag, notifies
// [R5] Warning sets summary and warning flag, notifies
// [R6] Restart waits until output below warning
// [R7] Host keeps warning below fault threshold; the monitor does not check it, and t_limits briefly sets fault below warning
// [R8] Reaction bits 7:6 must hold retry code
// [R9] Fault pulls alert low, flag sticky until clear
// [R10] Retry field zero latches output off
// [R11] Nonzero retry field retries until stopped
// [R12] Restart spacing is (delay+1) times 35ms
// [R13] Warning threshold defaults to 1.08 setpoint
// [R14] Fast rise may skip the warning record
// [R15] Both checks share one unsigned comparison scale
module oovm_monitor #(
  parameter int RETRY_UNIT_CYCLES = oovm_pkg::RETRY_UNIT_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Command port (transaction layer of the management bus)
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [oovm_pkg::VOUT_W-1:0] cmd_wdata,
  output logic [oovm_pkg::VOUT_W-1:0] cmd_rdata,
  output logic cmd_ack,
  output logic cmd_reject,
  // Measurement and strap
  input wire logic [oovm_pkg::VOUT_W-1:0] vout_meas,
  input wire logic [oovm_pkg::VOUT_W-1:0] setpoint_strap_pin,
  // Run conditions
  input wire logic enable_on,
  input wire logic bias_ok,
  input wire logic other_fault_off,
  // Power stage and status
  output logic power_stage_en,
  output logic restart_pulse,
  output logic vout_summary_flag,
  output logic overvoltage_warning_flag,
  output logic overvoltage_fault_flag,
  output logic alert_out_n
);
  import oovm_pkg::*;

  // ****************************************
  // Registers
  // ****************************************
  logic [VOUT_W-1:0] fault_thr_reg;
  logic [VOUT_W-1:0] warn_thr_reg;
  logic [7:0] reaction_reg;
  logic [VOUT_W-1:0] rdata_reg;
  logic ack_reg;
  logic reject_reg;
  logic fault_flag_reg;
  logic warn_flag_reg;
  logic alert_n_reg;
  logic stage_en_reg;
  logic restart_reg;
  oovm_state_t state_reg;
  oovm_state_t state_next;
  oovm_timer_if tif ();

  // ****************************************
  // Strap defaults and comparisons
  // ****************************************
  // Setpoint scaled to the fault and warning defaults
  // Wide enough that a full-span strap times 27 does not wrap
  wire [23:0] strap_wide = {8'h00, setpoint_strap_pin};
  wire [23:0] fault_prod = strap_wide * 24'(FAULT_NUM);
  wire [23:0] warn_prod = strap_wide * 24'(WARN_NUM);
  wire [23:0] fault_quot = fault_prod / 24'(FAULT_DEN);
  wire [23:0] warn_quot = warn_prod / 24'(WARN_DEN);
  wire [VOUT_W-1:0] fault_default = fault_quot[VOUT_W-1:0]; // R3
  wire [VOUT_W-1:0] warn_default = warn_quot[VOUT_W-1:0]; // R13
  // One unsigned scale for measurement and both thresholds
  wire fault_above = vout_meas > fault_thr_reg; // R1 R15
  wire warn_above = vout_meas > warn_thr_reg; // R15
  wire below_warn = vout_meas < warn_thr_reg; // R6
  wire stop_cond = !enable_on || !bias_ok || other_fault_off; // R11
  wire [2:0] retry_field = reaction_reg[RETRY_HI:RETRY_LO];

  // ****************************************
  // Command decode
  // ****************************************
  // Writes outside the span or with an unused reaction code are refused
  wire hit_fault = cmd_code == CMD_OV_FAULT_THR;
  wire hit_react = cmd_code == CMD_OV_REACTION;
  wire hit_warn = cmd_code == CMD_OV_WARN_THR;
  wire hit_clear = cmd_code == CMD_CLEAR_FAULTS;
  wire wr = cmd_valid && cmd_write;
  wire wr_fault_ok = wr && hit_fault && (cmd_wdata <= FAULT_THR_MAX); // R2
  wire wr_warn_ok = wr && hit_warn && (cmd_wdata <= WARN_THR_MAX); // R2
  wire wr_react_ok = wr && hit_react && (cmd_wdata[RESP_HI:RESP_LO] == RESP_RETRY); // R8
  wire clear_cmd = wr && hit_clear;
  wire rd_ok = cmd_valid && !cmd_write && (hit_fault || hit_react || hit_warn);
  wire cmd_ok = wr_fault_ok || wr_warn_ok || wr_react_ok || clear_cmd || rd_ok;
  wire [VOUT_W-1:0] rd_mux = hit_fault ? fault_thr_reg :
                             hit_warn ? warn_thr_reg : {8'h00, reaction_reg};

  // Threshold and reaction storage, threshold defaults caught from the strap in reset
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fault_thr_reg <= fault_default; // R3
      warn_thr_reg <= warn_default; // R13
      reaction_reg <= REACTION_RESET;
    end else begin
      if (wr_fault_ok) fault_thr_reg <= cmd_wdata;
      if (wr_warn_ok) warn_thr_reg <= cmd_wdata;
      if (wr_react_ok) reaction_reg <= cmd_wdata[7:0];
    end
  end

  // Answer one cycle after the request
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata_reg <= '0;
      ack_reg <= 1'b0;
      reject_reg <= 1'b0;
    end else begin
      if (rd_ok) rdata_reg <= rd_mux;
      ack_reg <= cmd_valid && cmd_ok;
      reject_reg <= cmd_valid && !cmd_ok; // R2
    end
  end

  // ****************************************
  // Status flags and alert
  // ****************************************
  // Sticky flags; a new event wins over a clear in the same cycle
  wire fault_flag_next = fault_above || (fault_flag_reg && !clear_cmd); // R4 R9
  wire warn_flag_next = warn_above || (warn_flag_reg && !clear_cmd); // R5 R14
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fault_flag_reg <= 1'b0;
      warn_flag_reg <= 1'b0;
      alert_n_reg <= 1'b1;
    end else begin
      fault_flag_reg <= fault_flag_next;
      warn_flag_reg <= warn_flag_next;
      alert_n_reg <= !(fault_flag_next || warn_flag_next); // R9
    end
  end

  // ****************************************
  // Fault reaction
  // ****************************************
  // Latch off on a zero retry field, otherwise wait out delay and low voltage
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (stop_cond) state_next = ST_OFF;
        else if (fault_above) state_next = (retry_field == RETRY_NONE) ? ST_LATCH : ST_RETRY; // R10 R8
      end
      ST_RETRY: begin
        if (stop_cond) state_next = ST_OFF; // R11
        else if (tif.expired && below_warn) state_next = ST_RUN; // R6 R12
      end
      ST_LATCH: state_next = ST_LATCH; // R10
      ST_OFF: begin
        if (!stop_cond) state_next = ST_RUN;
      end
      default: state_next = ST_OFF;
    endcase
  end
  assign tif.start = (state_reg == ST_RUN) && (state_next == ST_RETRY); // R12
  assign tif.code = reaction_reg[DELAY_HI:0];

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= ST_OFF;
      stage_en_reg <= 1'b0;
      restart_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      stage_en_reg <= state_next == ST_RUN;
      restart_reg <= (state_reg == ST_RETRY) && (state_next == ST_RUN); // R11
    end
  end

  oovm_retry_timer #(
    .UNIT_CYCLES(RETRY_UNIT_CYCLES)
  ) u_timer (
    .clk(clk),
    .reset_n(reset_n),
    .tif(tif)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign cmd_rdata = rdata_reg;
  assign cmd_ack = ack_reg;
  assign cmd_reject = reject_reg;
  assign power_stage_en = stage_en_reg;
  assign restart_pulse = restart_reg;
  assign vout_summary_flag = fault_flag_reg || warn_flag_reg; // R4 R5
  assign overvoltage_warning_flag = warn_flag_reg;
  assign overvoltage_fault_flag = fault_flag_reg;
  assign alert_out_n = alert_n_reg;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence seq_fault_seen;
    fault_above ##1 (overvoltage_fault_flag && vout_summary_flag && !alert_out_n);
  endsequence
  sequence seq_retry_exit;
    (state_reg == ST_RETRY && below_warn && tif.expired && !stop_cond) ##1 restart_pulse;
  endsequence
  a_fault_flag_alert: assert property (fault_above |-> seq_fault_seen) // R4
    else $error("fault did not set flag, summary and alert");
  a_warn_flag_set: assert property (warn_above |=> overvoltage_warning_flag && vout_summary_flag) // R5
    else $error("warning did not set its flag");
  a_fault_flag_sticky: assert property (overvoltage_fault_flag && !clear_cmd |=> overvoltage_fault_flag) // R9
    else $error("fault flag dropped without a clear");
  a_restart_below_warn: assert property ($rose(restart_pulse) |-> $past(below_warn) && $past(tif.expired)) // R6
    else $error("restart began above warning or before delay");
  a_retry_exit_path: assert property (state_reg == ST_RETRY && below_warn && tif.expired && !stop_cond
                                      |-> seq_retry_exit) // R11
    else $error("retry did not restart when allowed");
  a_latch_holds_off: assert property (state_reg == ST_LATCH |=> state_reg == ST_LATCH && !power_stage_en) // R10
    else $error("latched fault let the output run");
  a_retry_stops: assert property (state_reg == ST_RETRY && stop_cond |=> state_reg == ST_OFF) // R11
    else $error("retry continued after a stop condition");
  a_range_refused: assert property (wr && hit_fault && cmd_wdata > FAULT_THR_MAX
                                    |=> cmd_reject && $stable(fault_thr_reg)) // R2
    else $error("out-of-range fault threshold accepted");
  a_reaction_code: assert property (reaction_reg[RESP_HI:RESP_LO] == RESP_RETRY) // R8
    else $error("reaction register holds an unused code");
  a_strap_default: assert property ($past(!reset_n) |-> fault_thr_reg == $past(fault_default)
                                    && warn_thr_reg == $past(warn_default)) // R3
    else $error("thresholds not loaded from the strap");
endmodule
`default_nettype wire

// File: verilog/oovm_pkg.sv
// Package: constants and types of the output overvoltage fault monitor
`default_nettype none
package oovm_pkg;
  // ****************************************
  // Widths and command codes
  // ****************************************
  localparam int VOUT_W = 16;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_OV_FAULT_THR = 8'h40;
  localparam logic [7:0] CMD_OV_REACTION = 8'h41;
  localparam logic [7:0] CMD_OV_WARN_THR = 8'h42;
  // ****************************************
  // Field positions and values
  // ****************************************
  localparam int RESP_HI = 7;
  localparam int RESP_LO = 6;
  localparam int RETRY_HI = 5;
  localparam int RETRY_LO = 3;
  localparam int DELAY_HI = 2;
  localparam logic [1:0] RESP_RETRY = 2'h2;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [7:0] REACTION_RESET = 8'h80;
  // Thresholds are volts times 2^13; fault span up to 6.0 V, warning up to 5.5 V
  localparam logic [15:0] FAULT_THR_MAX = 16'hc000;
  localparam logic [15:0] WARN_THR_MAX = 16'hb000;
  // Strap scaling: fault 1.10, warning 1.08 of the setpoint
  localparam logic [19:0] FAULT_NUM = 20'h0_000b;
  localparam logic [19:0] FAULT_DEN = 20'h0_000a;
  localparam logic [19:0] WARN_NUM = 20'h0_001b;
  localparam logic [19:0] WARN_DEN = 20'h0_0019;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int RETRY_UNIT_MS = 35;
  localparam int RETRY_UNIT_CYCLES = RETRY_UNIT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int UNIT_W = 23;
  // ****************************************
  // Supervisor states
  // ****************************************
  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_LATCH = 4'h2,
    ST_RETRY = 4'h4,
    ST_OFF = 4'h8
  } oovm_state_t;
endpackage
`default_nettype wire

// File: verilog/oovm_retry_timer.sv
// Retry delay timer: (code + 1) units of the retry time step
`default_nettype none
module oovm_retry_timer #(
  parameter int UNIT_CYCLES = oovm_pkg::RETRY_UNIT_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Supervisor side
  oovm_timer_if.timer tif
);
  import oovm_pkg::*;
  logic [UNIT_W-1:0] unit_reg;
  logic [2:0] step_reg;
  logic [2:0] code_reg;
  logic run_reg;
  wire unit_end = (unit_reg == UNIT_W'(UNIT_CYCLES - 1));
  wire last_unit = unit_end && (step_reg == code_reg);
  // Counts whole units, then steps until the coded count is reached
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      unit_reg <= '0;
      step_reg <= '0;
      code_reg <= '0;
      run_reg <= 1'b0;
    end else if (tif.start) begin
      unit_reg <= '0;
      step_reg <= '0;
      code_reg <= tif.code; // R12
      run_reg <= 1'b1;
    end else if (run_reg) begin
      unit_reg <= unit_end ? '0 : unit_reg + 1'b1;
      step_reg <= unit_end ? step_reg + 1'b1 : step_reg; // R12
      run_reg <= !last_unit;
    end
  end
  assign tif.expired = !run_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_timer_ends_last: assert property (run_reg && last_unit && !tif.start |=> !run_reg && tif.expired) // R12
    else $error("retry timer did not end after its last unit");
  a_timer_starts_clear: assert property (tif.start |=> run_reg && unit_reg == '0 && step_reg == '0) // R12
    else $error("retry timer did not restart from zero");
endmodule
`default_nettype wire

// File: verilog/oovm_timer_if.sv
// Interface: start and expiry between supervisor and retry-delay timer
`default_nettype none
interface oovm_timer_if;
  logic start;
  logic [2:0] code;
  logic expired;
  modport ctrl (output start, output code, input expired);
  modport timer (input start, input code, output expired);
endinterface
`default_nettype wire
